// >>> hw/spi_flash_status_register.sv
// two-byte status register of a serial flash, served over the spi pins
//
// Function
// [R1] host selects, shifts opcode 05h; device then drives status bits every clock.
// [R2] byte one msb first, then byte two msb first, repeating while selected.
// [R3] every two-byte repetition carries a freshly sampled snapshot.
// [R4] status read is served at any time, even while busy.
// [R5] chip select release ends the read at any bit; output goes high impedance.
// [R6] write status changes only bits 7 and 2 of byte one.
// [R7] byte one bit 4 mirrors the write-protect pin: 0 asserted, 1 deasserted.
// [R8] lock set and pin asserted: array-protect bit cannot change.
// [R9] protection lock is 0 after power-up.
// [R10] pin asserted: lock may only go 0 to 1; pin deasserted: free.
// [R11] error bit set when the last program or erase failed.
// [R12] error bit untouched by aborts; refreshed after every program and erase.
// [R13] array-protect 0 allows program and erase; 1 blocks them.
// [R14] write-enable latch 0 rejects program, erase, otp and write status.
// [R15] write-enable latch is 0 after power-up and after reset.
// [R16] latch cleared when write-type operations finish or abort, or on hold stop.
// [R17] incomplete opcode keeps latch; full write-type opcode then stop clears it.
// [R18] busy bit in bit 0 of both bytes, 1 while an operation runs.
// [R19] host polls status until busy falls from 1 to 0.
// [R20] byte two bit 4 enables the reset command; 0 by default ignores it.
// [R21] soft-reset enable changes only by write status two or power cycle.
// [R22] opcode 01h plus a byte writes lock and protect bits at release.
// [R23] opcode 31h plus a byte writes soft-reset enable at release.
// [R24] reserved bits read 0 and are never written.
`timescale 1ns/10ps
`default_nettype none
`include "status_reg_map.svh"

module spi_flash_status_register (
  // clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // serial pins, asynchronous to core_clk
  input  wire status_reg_pkg::spi_pins_t      pins,
  output logic                                so_out,
  output logic                                so_oe,
  // program and erase engine, core_clk domain
  input  wire status_reg_pkg::engine_status_t eng,
  // state offered to the rest of the device
  output logic                                array_writable,
  output logic                                write_enable_latch,
  output logic                                soft_reset_enable,
  output logic                                soft_reset_go,
  output logic [7:0]                          status_byte_one,
  output logic [7:0]                          status_byte_two
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_write_type(input logic [7:0] op);
    is_write_type = (op == `OP_BYTE_PROGRAM) || (op == `OP_ERASE_PAGE) ||
                    (op == `OP_ERASE_4K) || (op == `OP_ERASE_32K) ||
                    (op == `OP_ERASE_32K_ALT) || (op == `OP_ERASE_CHIP) ||
                    (op == `OP_ERASE_CHIP_ALT) || (op == `OP_PROGRAM_OTP) ||
                    (op == `OP_WRITE_STATUS) || (op == `OP_WRITE_STATUS_TWO);
  endfunction : is_write_type

  // whole data byte received and release on a byte boundary
  function automatic logic data_complete(input logic [4:0] cnt);
    data_complete = cnt[4] && (cnt[2:0] == 3'h0);
  endfunction : data_complete

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic       sck_prev;
  logic       cs_n_prev;
  logic [3:0] next_pin_meta;
  logic [3:0] next_pin_sync;
  logic       next_sck_prev;
  logic       next_cs_n_prev;

  always_comb begin
    next_pin_meta  = {pins.cs_n, pins.sck, pins.si, pins.wp_n};
    next_pin_sync  = pin_meta;
    next_sck_prev  = pin_sync[2];
    next_cs_n_prev = pin_sync[3];
  end

  // deselected and idle after reset so no false frame start is seen
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_meta  <= 4'h9;
      pin_sync  <= 4'h9;
      sck_prev  <= 1'b0;
      cs_n_prev <= 1'b1;
    end else begin
      pin_meta  <= next_pin_meta;
      pin_sync  <= next_pin_sync;
      sck_prev  <= next_sck_prev;
      cs_n_prev <= next_cs_n_prev;
    end
  end

  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_n_s;
  logic selected;
  logic sck_rise;
  logic sck_fall;
  logic cs_start;
  logic cs_end;

  assign cs_n_s   = pin_sync[3];
  assign sck_s    = pin_sync[2];
  assign si_s     = pin_sync[1];
  assign wp_n_s   = pin_sync[0];
  assign selected = ~cs_n_s;
  assign sck_rise = selected & sck_s & ~sck_prev;
  assign sck_fall = selected & ~sck_s & sck_prev;
  assign cs_start = ~cs_n_s & cs_n_prev;
  assign cs_end   = cs_n_s & ~cs_n_prev;

  // ------------------------------------------------------------
  // status fields
  // ------------------------------------------------------------
  logic       protect_lock_bit;
  logic       array_protect_bit;
  logic       write_enable_bit;
  logic       erase_program_error;
  logic       soft_reset_bit;
  logic [7:0] live_one;
  logic [7:0] live_two;

  always_comb begin
    live_one = 8'h00;                                  // see [R24]
    live_one[`B1_PROTECT_LOCK]  = protect_lock_bit;
    live_one[`B1_ERROR]         = erase_program_error;
    live_one[`B1_WP_PIN]        = wp_n_s;              // see [R7]
    live_one[`B1_ARRAY_PROTECT] = array_protect_bit;
    live_one[`B1_WEL]           = write_enable_bit;
    live_one[`B1_BUSY]          = eng.busy;            // see [R18]
    live_two = 8'h00;                                  // see [R24]
    live_two[`B2_SOFT_RESET_EN] = soft_reset_bit;
    live_two[`B2_BUSY]          = eng.busy;            // see [R18]
  end

  // ------------------------------------------------------------
  // frame decode and status shifter
  // ------------------------------------------------------------
  status_reg_pkg::frame_state_t state;
  status_reg_pkg::frame_state_t next_state;
  logic [4:0]  bit_cnt;
  logic [7:0]  shift_in;
  logic [7:0]  opcode;
  logic [7:0]  data_byte;
  logic [3:0]  out_pos;
  logic [15:0] out_shift;
  logic        out_bit;
  logic        out_en;
  logic [4:0]  next_bit_cnt;
  logic [7:0]  next_shift_in;
  logic [7:0]  next_opcode;
  logic [7:0]  next_data_byte;
  logic [3:0]  next_out_pos;
  logic [15:0] next_out_shift;
  logic        next_out_bit;
  logic        next_out_en;

  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shift_in  = shift_in;
    next_opcode    = opcode;
    next_data_byte = data_byte;
    next_out_pos   = out_pos;
    next_out_shift = out_shift;
    next_out_bit   = out_bit;
    next_out_en    = out_en;
    if (!selected) begin
      next_state  = status_reg_pkg::ST_IDLE;
      next_out_en = 1'b0;                              // see [R5]
    end else if (cs_start) begin
      next_state   = status_reg_pkg::ST_OPCODE;
      next_bit_cnt = 5'h00;
      next_out_pos = 4'h0;
    end else begin
      if (sck_rise) begin
        next_shift_in = {shift_in[6:0], si_s};
        // stays between 16 and 23 so byte boundaries remain visible
        next_bit_cnt  = (bit_cnt == `BIT_CNT_WRAP) ? `OPCODE_DATA_BITS : bit_cnt + 5'h01;
        if (bit_cnt == `OPCODE_BITS - 5'h01) begin
          next_opcode = {shift_in[6:0], si_s};
        end
        if (bit_cnt == `OPCODE_DATA_BITS - 5'h01) begin
          next_data_byte = {shift_in[6:0], si_s};      // later bytes ignored
        end
        unique case (state)
          status_reg_pkg::ST_IDLE: begin
            next_state = status_reg_pkg::ST_IDLE;
          end
          status_reg_pkg::ST_OPCODE: begin
            if (bit_cnt == `OPCODE_BITS - 5'h01) begin
              next_state = status_reg_pkg::ST_BODY;
            end
          end
          status_reg_pkg::ST_BODY: begin
            next_state = status_reg_pkg::ST_BODY;
          end
        endcase
      end
      // served regardless of busy; snapshot taken at each byte one start
      if (sck_fall && state == status_reg_pkg::ST_BODY && opcode == `OP_READ_STATUS) begin // see [R1] see [R4]
        next_out_en  = 1'b1;
        next_out_pos = out_pos + 4'h1;                 // see [R2]
        if (out_pos == 4'h0) begin
          next_out_bit   = live_one[7];                // see [R3]
          next_out_shift = {live_one[6:0], live_two, 1'b0};
        end else begin
          next_out_bit   = out_shift[15];
          next_out_shift = {out_shift[14:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state     <= status_reg_pkg::ST_IDLE;
      bit_cnt   <= 5'h00;
      shift_in  <= 8'h00;
      opcode    <= 8'h00;
      data_byte <= 8'h00;
      out_pos   <= 4'h0;
      out_shift <= 16'h0000;
      out_bit   <= 1'b0;
      out_en    <= 1'b0;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shift_in  <= next_shift_in;
      opcode    <= next_opcode;
      data_byte <= next_data_byte;
      out_pos   <= next_out_pos;
      out_shift <= next_out_shift;
      out_bit   <= next_out_bit;
      out_en    <= next_out_en;
    end
  end

  assign so_out = out_bit;
  assign so_oe  = out_en & selected;                   // see [R5]

  // ------------------------------------------------------------
  // register updates
  // ------------------------------------------------------------
  logic       next_protect_lock_bit;
  logic       next_array_protect_bit;
  logic       next_write_enable_bit;
  logic       next_erase_program_error;
  logic       next_soft_reset_bit;
  logic       next_soft_reset_go;
  logic       full_opcode;
  logic       wp_asserted;
  logic       reset_exec;

  always_comb begin
    next_protect_lock_bit    = protect_lock_bit;
    next_array_protect_bit   = array_protect_bit;
    next_write_enable_bit    = write_enable_bit;
    next_erase_program_error = erase_program_error;
    next_soft_reset_bit      = soft_reset_bit;
    full_opcode              = (state == status_reg_pkg::ST_BODY);
    wp_asserted              = ~wp_n_s;
    // reset command honoured only when enabled; it never touches the enable
    reset_exec               = eng.soft_reset_req & soft_reset_bit;  // see [R20] see [R21]
    next_soft_reset_go       = reset_exec;
    // failures set the error, aborts leave it alone
    if (eng.op_done) begin
      next_erase_program_error = eng.op_fail;          // see [R11] see [R12]
    end
    if (eng.op_done || eng.op_abort || eng.hold_stop || reset_exec) begin
      next_write_enable_bit = 1'b0;                    // see [R15] see [R16]
    end
    // a frame cut inside the opcode changes nothing
    if (cs_end && full_opcode) begin                   // see [R17]
      if (opcode == `OP_WRITE_STATUS && write_enable_bit) begin  // see [R14]
        if (data_complete(bit_cnt)) begin              // see [R22]
          if (wp_asserted && protect_lock_bit) begin
            next_array_protect_bit = array_protect_bit;           // see [R8]
          end else if (wp_asserted) begin
            next_protect_lock_bit  = data_byte[`B1_PROTECT_LOCK]; // see [R10]
            next_array_protect_bit = data_byte[`B1_ARRAY_PROTECT];// see [R6]
          end else begin
            next_protect_lock_bit  = data_byte[`B1_PROTECT_LOCK]; // see [R10]
            next_array_protect_bit = data_byte[`B1_ARRAY_PROTECT];// see [R6]
          end
        end
      end
      if (opcode == `OP_WRITE_STATUS_TWO && write_enable_bit && data_complete(bit_cnt)) begin // see [R14]
        next_soft_reset_bit = data_byte[`B2_SOFT_RESET_EN];        // see [R23]
      end
      if (is_write_type(opcode) || opcode == `OP_WRITE_DISABLE) begin
        next_write_enable_bit = 1'b0;                  // see [R16] see [R17]
      end
      // set evaluated last so it wins over a same-cycle clear
      if (opcode == `OP_WRITE_ENABLE && bit_cnt == `OPCODE_BITS) begin
        next_write_enable_bit = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      protect_lock_bit    <= `RST_PROTECT_LOCK;        // see [R9]
      array_protect_bit   <= `RST_ARRAY_PROTECT;
      write_enable_bit    <= `RST_WEL;                 // see [R15]
      erase_program_error <= `RST_ERROR;
      soft_reset_bit      <= `RST_SOFT_RESET_EN;       // see [R20]
      soft_reset_go       <= 1'b0;
      array_writable      <= 1'b0;
      write_enable_latch  <= `RST_WEL;
      soft_reset_enable   <= `RST_SOFT_RESET_EN;
      status_byte_one     <= 8'h00;
      status_byte_two     <= 8'h00;
    end else begin
      protect_lock_bit    <= next_protect_lock_bit;
      array_protect_bit   <= next_array_protect_bit;
      write_enable_bit    <= next_write_enable_bit;
      erase_program_error <= next_erase_program_error;
      soft_reset_bit      <= next_soft_reset_bit;
      soft_reset_go       <= next_soft_reset_go;
      array_writable      <= next_write_enable_bit & ~next_array_protect_bit;  // see [R13] see [R14]
      write_enable_latch  <= next_write_enable_bit;
      soft_reset_enable   <= next_soft_reset_bit;
      status_byte_one     <= live_one;
      status_byte_two     <= live_two;
    end
  end

endmodule : spi_flash_status_register

`default_nettype wire

// >>> hw/status_reg_map.svh
// field positions, opcodes, reset values and frame bit counts of the status register bank
`ifndef STATUS_REG_MAP_SVH
`define STATUS_REG_MAP_SVH

// opcodes
`define OP_READ_STATUS      8'h05
`define OP_WRITE_STATUS     8'h01
`define OP_WRITE_STATUS_TWO 8'h31
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04
`define OP_BYTE_PROGRAM     8'h02
`define OP_ERASE_PAGE       8'h81
`define OP_ERASE_4K         8'h20
`define OP_ERASE_32K        8'h52
`define OP_ERASE_32K_ALT    8'hd8
`define OP_ERASE_CHIP       8'h60
`define OP_ERASE_CHIP_ALT   8'hc7
`define OP_PROGRAM_OTP      8'h9b

// byte one field positions
`define B1_PROTECT_LOCK   7
`define B1_ERROR          5
`define B1_WP_PIN         4
`define B1_ARRAY_PROTECT  2
`define B1_WEL            1
`define B1_BUSY           0
// byte two field positions
`define B2_SOFT_RESET_EN  4
`define B2_BUSY           0

// reset values
`define RST_PROTECT_LOCK  1'b0
`define RST_ARRAY_PROTECT 1'b0
`define RST_WEL           1'b0
`define RST_ERROR         1'b0
`define RST_SOFT_RESET_EN 1'b0

// frame bit counts
`define OPCODE_BITS       5'h08
`define OPCODE_DATA_BITS  5'h10
`define BIT_CNT_WRAP      5'h17

`endif

// >>> hw/status_reg_pkg.sv
// types shared by the status register bank
package status_reg_pkg;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } spi_pins_t;

  typedef struct packed {
    logic busy;
    logic op_done;
    logic op_fail;
    logic op_abort;
    logic hold_stop;
    logic soft_reset_req;
  } engine_status_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_OPCODE = 2'b01,
    ST_BODY   = 2'b11
  } frame_state_t;

endpackage : status_reg_pkg

// >>> sim/status_reg_asserts.sv
// concurrent checks on the ports of the status register bank
`timescale 1ns/10ps
`default_nettype none

module status_reg_asserts (
  // clock and reset
  input wire logic                           core_clk,
  input wire logic                           rst,
  // serial side
  input wire status_reg_pkg::spi_pins_t      pins,
  input wire logic                           so_out,
  input wire logic                           so_oe,
  // engine and device side
  input wire status_reg_pkg::engine_status_t eng,
  input wire logic                           array_writable,
  input wire logic                           write_enable_latch,
  input wire logic                           soft_reset_enable,
  input wire logic                           soft_reset_go,
  input wire logic [7:0]                     status_byte_one,
  input wire logic [7:0]                     status_byte_two
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_oe_after_deselect: assert property (pins.cs_n [*3] |-> !so_oe)
    else $error("so_oe still high after deselect");
  a_reserved_zero: assert property ({status_byte_one[6], status_byte_one[3],
    status_byte_two[7:5], status_byte_two[3:1]} == 8'h00) else $error("reserved status bit set");
  a_busy_both_bytes: assert property (status_byte_one[0] == status_byte_two[0])
    else $error("busy differs between bytes");
  a_busy_live: assert property (eng.busy [*4] |-> status_byte_one[0])
    else $error("busy bit not following engine");
  a_pin_mirror: assert property ($stable(pins.wp_n) [*4] |-> status_byte_one[4] == pins.wp_n)
    else $error("pin state bit wrong");
  a_writable_on: assert property ((write_enable_latch && !status_byte_one[2]) [*3] |-> array_writable)
    else $error("array not writable");
  a_writable_off: assert property (status_byte_one[2] [*3] |-> !array_writable)
    else $error("protected array writable");
  a_reset_go: assert property (eng.soft_reset_req && soft_reset_enable |=> soft_reset_go)
    else $error("reset command not executed");
  a_reset_gated: assert property (soft_reset_go |-> soft_reset_enable)
    else $error("reset executed while disabled");
  a_error_set: assert property (eng.op_done && eng.op_fail |-> ##[1:3] status_byte_one[5])
    else $error("error bit not set");
  a_latch_cleared: assert property (eng.op_done |-> ##[1:3] !write_enable_latch)
    else $error("latch not cleared by engine");
endmodule : status_reg_asserts

bind spi_flash_status_register status_reg_asserts status_reg_asserts_inst (
  .core_clk(core_clk), .rst(rst), .pins(pins), .so_out(so_out), .so_oe(so_oe), .eng(eng),
  .array_writable(array_writable), .write_enable_latch(write_enable_latch),
  .soft_reset_enable(soft_reset_enable), .soft_reset_go(soft_reset_go),
  .status_byte_one(status_byte_one), .status_byte_two(status_byte_two));

`default_nettype wire

// >>> sim/spi_host_model.sv
// host-side serial controller model driving the flash pins
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // mode 0 frame, msb first; an undriven so reads as unknown so it never matches
  // pins move by nonblocking assignment: some steps land on a core_clk edge
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = 40'h00_0000_0000;
    #7 cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si <= tx[i];
      #24 sck <= 1'b1;
      rx = {rx[38:0], so_oe ? so_out : 1'bx};
      #24 sck <= 1'b0;
    end
    #24 cs_n <= 1'b1;
    // released line must not look like held data
    si <= ~si;
    #40;
  endtask : xfer
endmodule : spi_host_model

`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the status register bank
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic                           core_clk = 1'b0;
  logic                           rst = 1'b1;
  logic                           wp_n = 1'b1;
  status_reg_pkg::engine_status_t eng = 6'b00_0000;
  status_reg_pkg::spi_pins_t      pins;
  logic                           cs_n, sck, si, so_out, so_oe;
  logic                           array_writable, write_enable_latch, soft_reset_enable, soft_reset_go;
  logic [7:0]                     status_byte_one, status_byte_two;
  logic [31:0]                    rd;
  int                             num_errors = 0;
  int                             checked = 0;
  int                             go_cnt = 0;
  int                             cycles = 0;

  assign pins = {cs_n, sck, si, wp_n};
  always #2.5 core_clk = ~core_clk;

  spi_flash_status_register spi_flash_status_register_inst (.core_clk(core_clk), .rst(rst), .pins(pins),
    .so_out(so_out), .so_oe(so_oe), .eng(eng), .array_writable(array_writable),
    .write_enable_latch(write_enable_latch), .soft_reset_enable(soft_reset_enable),
    .soft_reset_go(soft_reset_go), .status_byte_one(status_byte_one), .status_byte_two(status_byte_two));
  spi_host_model spi_host_model_inst (.cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe));

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (soft_reset_go === 1'b1) go_cnt <= go_cnt + 1;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic frame(input logic [39:0] tx, input int n);
    logic [39:0] rx;
    spi_host_model_inst.xfer(tx, n, rx);
    rd = rx[31:0];
    settle();
  endtask : frame

  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    frame(40'h00_0000_0006, 8);
    frame({24'h00_0000, op, d}, 16);
  endtask : wr

  task automatic pulse(input logic [5:0] v);
    @(posedge core_clk);
    eng <= status_reg_pkg::engine_status_t'(v);
    @(posedge core_clk);
    eng <= 6'b00_0000;
    settle();
  endtask : pulse

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    settle();
    chk8("byte one", 8'h10, status_byte_one);
    chk8("byte two", 8'h00, status_byte_two);
    $display("test reset done");
  endtask : t_reset

  task automatic t_read();
    @(posedge core_clk);
    eng.busy <= 1'b1;
    fork
      frame(40'h05_0000_0000, 40);
      begin
        repeat (180) @(posedge core_clk);
        eng.busy <= 1'b0;
      end
    join
    // first pass busy, second pass idle, one fixed two-pass read frame saw it fall
    for (int k = 0; k < 4; k++) begin
      chk8("read byte", 8'(32'h1101_1000 >> (24 - 8 * k)), rd[31 - 8 * k -: 8]);
    end
    $display("test read done");
  endtask : t_read

  task automatic t_write();
    frame(40'h00_0000_01ff, 16);
    chk8("byte one", 8'h10, status_byte_one);
    wr(8'h01, 8'hff);
    chk8("byte one", 8'h94, status_byte_one);
    chk1("latch", 1'b0, write_enable_latch);
    wr(8'h31, 8'hff);
    chk8("byte two", 8'h10, status_byte_two);
    frame(40'h05_0000_0000, 40);
    chk8("read byte", 8'h10, rd[23:16]);
    $display("test write done");
  endtask : t_write

  task automatic t_lock();
    @(posedge core_clk);
    wp_n <= 1'b0;
    settle();
    chk8("byte one", 8'h84, status_byte_one);
    wr(8'h01, 8'h80);
    chk8("byte one", 8'h84, status_byte_one);
    wr(8'h01, 8'h00);
    chk8("byte one", 8'h84, status_byte_one);
    @(posedge core_clk);
    wp_n <= 1'b1;
    wr(8'h01, 8'h00);
    chk8("byte one", 8'h10, status_byte_one);
    @(posedge core_clk);
    wp_n <= 1'b0;
    wr(8'h01, 8'h80);
    chk8("byte one", 8'h80, status_byte_one);
    @(posedge core_clk);
    wp_n <= 1'b1;
    wr(8'h01, 8'h00);
    $display("test lock done");
  endtask : t_lock

  task automatic t_latch();
    frame(40'h00_0000_0006, 8);
    frame(40'h00_0000_0000, 4);
    chk1("latch", 1'b1, write_enable_latch);
    chk1("writable", 1'b1, array_writable);
    frame(40'h00_0000_0002, 8);
    chk1("latch", 1'b0, write_enable_latch);
    frame(40'h00_0000_0006, 8);
    frame(40'h00_0000_0004, 8);
    chk1("latch", 1'b0, write_enable_latch);
    frame(40'h00_0000_0006, 8);
    pulse(6'b01_1000);
    chk8("byte one", 8'h30, status_byte_one);
    frame(40'h00_0000_0006, 8);
    pulse(6'b00_0100);
    chk8("byte one", 8'h30, status_byte_one);
    frame(40'h00_0000_0006, 8);
    pulse(6'b00_0010);
    chk1("latch", 1'b0, write_enable_latch);
    pulse(6'b01_0000);
    chk8("byte one", 8'h10, status_byte_one);
    wr(8'h01, 8'h04);
    frame(40'h00_0000_0006, 8);
    chk1("writable", 1'b0, array_writable);
    $display("test latch done");
  endtask : t_latch

  task automatic t_soft_reset();
    // latch was left set by the last scenario; the executed reset must drop it
    pulse(6'b00_0001);
    chk8("reset count", 8'h01, 8'(go_cnt));
    chk1("reset enable", 1'b1, soft_reset_enable);
    chk1("latch", 1'b0, write_enable_latch);
    wr(8'h31, 8'h00);
    pulse(6'b00_0001);
    chk8("reset count", 8'h01, 8'(go_cnt));
    $display("test soft reset done");
  endtask : t_soft_reset

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_read();
    t_write();
    t_lock();
    t_latch();
    t_soft_reset();
    test_done();
  end
endmodule : tb_top

`default_nettype wire
